// ==== include/lin_sbc_defines.vh ====
// register addresses, field positions, reset values and timing counts
`ifndef LIN_SBC_DEFINES_VH
`define LIN_SBC_DEFINES_VH
`define ADDR_MODE_CTRL 4'h0
`define ADDR_VOLT_STAT 4'h1
`define ADDR_LIN_CTRL 4'h4
`define ADDR_LIN_STAT 4'h5
`define ADDR_HS_CTRL 4'h6
`define ADDR_HS_STAT 4'h7
`define ADDR_IRQ_MASK 4'he
`define ADDR_IRQ_SRC 4'hf
`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h1
`define MODE_SLEEP 2'h2
`define MODE_NORMAL_WDC 2'h3
`define SLEW_20K 2'h1
`define MODE_CTRL_RST 4'hc
`define LIN_CTRL_RST 4'h1
`define IMR_HS_BIT 3
`define IMR_LIN_BIT 1
`define IMR_VM_BIT 0
`define ISR_HS_BIT 3
`define ISR_WAKE_BIT 2
`define ISR_LIN_BIT 1
`define ISR_VM_BIT 0
`define SPI_BITS 4'h8
`define CLK_PERIOD_NS 8
`define TX_STUCK_DOMINANT_FLAG_TIME_MS 1000
`define TX_STUCK_DOMINANT_FLAG_CYCLES (`TX_STUCK_DOMINANT_FLAG_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define WAKE_DOM_TIME_US 100
`define WAKE_DOM_CYCLES (`WAKE_DOM_TIME_US * 1000 / `CLK_PERIOD_NS + 1)
`endif

// ==== rtl/sync2.v ====
// two flip-flop synchroniser for one level
module sync2 (
   input wire clk_in,
   input wire nrst_in,
   input wire d_in,
   output wire q_out
);
   reg meta_ff;
   reg q_ff;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         meta_ff <= 1'b0;
         q_ff <= 1'b0;
      end else begin
         meta_ff <= d_in;
         q_ff <= meta_ff;
      end
   end
   assign q_out = q_ff;
endmodule

// ==== rtl/lin_hs_fault_spi.v ====
// fault handling, lin control, wake detection and spi register slave
`include "lin_sbc_defines.vh"
module lin_hs_fault_spi #(
   parameter TX_STUCK_DOMINANT_FLAG_CYCLES = `TX_STUCK_DOMINANT_FLAG_CYCLES,
   parameter WAKE_CYCLES = `WAKE_DOM_CYCLES
) (
   // clock and reset
   input wire clk_in,
   input wire nrst_in,
   input wire por_in,
   input wire reset_mode_in,
   input wire external_reset_pin_in,
   // spi pins
   input wire spi_cs_n_in,
   input wire spi_sclk_in,
   input wire spi_mosi_in,
   output reg spi_miso_out,
   output reg spi_miso_oe_n_out,
   // analog fault and status inputs
   input wire hs_overtemp_in,
   input wire high_voltage_in,
   input wire [3:0] voltage_status_in,
   input wire [1:0] hs_open_load_in,
   input wire [1:0] hs_current_limit_in,
   input wire lin_overcurrent_in,
   input wire lin_overtemp_in,
   input wire rx_short_in,
   input wire tx_input_pin_in,
   input wire rx_output_pin_in,
   input wire lin_bus_in,
   // control outputs
   output reg [1:0] hs_drive_out,
   output reg lin_tx_enable_out,
   output reg lin_pullup_on_out,
   output reg lin_wake_thresh_out,
   output reg [1:0] lin_slew_select_out,
   output reg [1:0] op_mode_out,
   output reg rx_follow_bus_out,
   output reg wake_reset_out,
   output reg irq_n_out
);
   // synchronised pins
   wire cs_n_s, sclk_s, mosi_s, txd_s, rxd_s, bus_s, ext_rst_n_s;
   wire hs_ot_s, hv_s, loc_s, lot_s, rxsh_s;
   wire [3:0] vstat_s;
   wire [3:0] hol_s;
   wire [14:0] raw_w;
   wire [14:0] syn_w;
   // idle-high pins cross inverted so sync reset gives idle, no false edge
   assign raw_w = {~spi_cs_n_in, spi_sclk_in, spi_mosi_in, ~tx_input_pin_in,
      ~rx_output_pin_in, ~lin_bus_in, ~external_reset_pin_in, hs_overtemp_in,
      high_voltage_in, lin_overcurrent_in, lin_overtemp_in, rx_short_in,
      voltage_status_in[3], hs_open_load_in[1], hs_current_limit_in[1]};
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
         sync2 u_sync (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(raw_w[gi]),
            .q_out(syn_w[gi])
         );
      end
   endgenerate
   wire [5:0] raw2_w;
   wire [5:0] syn2_w;
   assign raw2_w = {voltage_status_in[2:0], hs_open_load_in[0],
      hs_current_limit_in[0], 1'b0};
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync2
         sync2 u_sync (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .d_in(raw2_w[gi]),
            .q_out(syn2_w[gi])
         );
      end
   endgenerate
   assign {cs_n_s, sclk_s, mosi_s, txd_s, rxd_s, bus_s, ext_rst_n_s,
      hs_ot_s, hv_s, loc_s, lot_s, rxsh_s} = syn_w[14:3] ^ 12'h9e0;
   assign vstat_s = {syn_w[2], syn2_w[5:3]};
   // hs status layout: op2 cl2 op1 cl1
   assign hol_s = {syn_w[1], syn_w[0], syn2_w[2], syn2_w[1]};

   // register reset: sync reset, por, reset mode or external pin
   wire soft_rst = !nrst_in || por_in || reset_mode_in || !ext_rst_n_s;

   // edge detection on synchronised signals
   reg cs_n_d_ff, sclk_d_ff, rxd_d_ff, bus_d_ff;
   wire cs_fall = cs_n_d_ff && !cs_n_s;
   wire cs_rise = !cs_n_d_ff && cs_n_s;
   wire sclk_rise = !sclk_d_ff && sclk_s;
   wire sclk_fall = sclk_d_ff && !sclk_s;
   wire rxd_edge = rxd_d_ff ^ rxd_s;
   wire bus_rise = !bus_d_ff && bus_s;

   // registers
   reg [3:0] mode_ctrl_ff;
   reg [3:0] lin_ctrl_ff;
   reg [3:0] hs_ctrl_ff;
   reg [3:0] irq_mask_ff;
   reg [3:0] irq_src_ff;
   reg power_on_flag_ff;
   reg lin_overcurrent_flag_ff, lin_overtemp_flag_ff;
   reg rx_pin_short_flag_ff, tx_stuck_dominant_flag_ff;
   reg hs_off_ff;
   reg hs_thermal_ff;
   reg lin_ot_block_ff, rx_short_block_ff, tx_stuck_dominant_flag_block_ff;
   reg [31:0] tx_stuck_dominant_flag_cnt_ff;
   reg [31:0] wake_cnt_ff;
   reg wake_armed_ff;
   // spi
   reg [3:0] bit_cnt_ff;
   reg [7:0] rx_sh_ff;
   reg [7:0] tx_sh_ff;
   reg active_ff;

   wire [3:0] hs_status = hs_thermal_ff ? 4'hf : hol_s;
   wire [3:0] lin_status = {rx_pin_short_flag_ff, tx_stuck_dominant_flag_ff,
      lin_overtemp_flag_ff, lin_overcurrent_flag_ff};
   wire [3:0] volt_status = {vstat_s[3:1], power_on_flag_ff};
   wire [2:0] summary = {|volt_status, |lin_status, |hs_status};

   function [3:0] read_mux;
      input [3:0] a;
      input [3:0] vs, ls, hs, irq_source_reg;
      begin
         case (a)
            `ADDR_MODE_CTRL, `ADDR_VOLT_STAT: read_mux = vs;
            `ADDR_LIN_CTRL, `ADDR_LIN_STAT: read_mux = ls;
            `ADDR_HS_CTRL, `ADDR_HS_STAT: read_mux = hs;
            `ADDR_IRQ_MASK, `ADDR_IRQ_SRC: read_mux = irq_source_reg;
            default: read_mux = 4'h0;
         endcase
      end
   endfunction

   // a completed valid frame
   wire frame_ok = cs_rise && active_ff && bit_cnt_ff == `SPI_BITS;
   wire [3:0] f_addr = rx_sh_ff[7:4];
   wire [3:0] f_data = rx_sh_ff[3:0];
   wire wr_hs = frame_ok && f_addr == `ADDR_HS_CTRL;
   wire rd_lin = frame_ok && (f_addr == `ADDR_LIN_CTRL ||
      f_addr == `ADDR_LIN_STAT);
   wire acc_volt = frame_ok && (f_addr == `ADDR_MODE_CTRL ||
      f_addr == `ADDR_VOLT_STAT);
   wire [1:0] mode = mode_ctrl_ff[1:0];
   wire low_power = mode == `MODE_STOP || mode == `MODE_SLEEP;
   wire hv_shut = mode_ctrl_ff[3] && hv_s;
   wire tx_lin_err = lot_s || rxsh_s || tx_stuck_dominant_flag_cnt_ff >= TX_STUCK_DOMINANT_FLAG_CYCLES;
   wire any_lin_err = loc_s || tx_lin_err;

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         cs_n_d_ff <= 1'b1;
         sclk_d_ff <= 1'b0;
         rxd_d_ff <= 1'b1;
         bus_d_ff <= 1'b1;
      end else begin
         cs_n_d_ff <= cs_n_s;
         sclk_d_ff <= sclk_s;
         rxd_d_ff <= rxd_s;
         bus_d_ff <= bus_s;
      end
   end

   // spi shifter
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         bit_cnt_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         tx_sh_ff <= 8'h00;
         active_ff <= 1'b0;
         spi_miso_out <= 1'b0;
         spi_miso_oe_n_out <= 1'b1;
      end else if (cs_fall) begin
         active_ff <= 1'b1;
         bit_cnt_ff <= 4'h0;
         // latch summary and the previous address's status
         tx_sh_ff <= {summary, 1'b0,
            read_mux(rx_sh_ff[7:4], volt_status, lin_status, hs_status,
               irq_src_ff)};
         spi_miso_oe_n_out <= 1'b0;
         spi_miso_out <= summary[2];
      end else if (cs_n_s) begin
         active_ff <= 1'b0;
         spi_miso_oe_n_out <= 1'b1;
      end else if (active_ff) begin
         if (sclk_rise) begin
            spi_miso_out <= tx_sh_ff[7];
         end
         if (sclk_fall) begin
            rx_sh_ff <= {rx_sh_ff[6:0], mosi_s};
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            if (bit_cnt_ff != 4'hf) begin
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
         end
      end
   end

   // register file and fault logic
   always @(posedge clk_in) begin
      if (soft_rst) begin
         mode_ctrl_ff <= `MODE_CTRL_RST;
         lin_ctrl_ff <= `LIN_CTRL_RST;
         hs_ctrl_ff <= 4'h0;
         irq_mask_ff <= 4'h0;
         irq_src_ff <= 4'h0;
         power_on_flag_ff <= por_in || !nrst_in;
         lin_overcurrent_flag_ff <= 1'b0;
         lin_overtemp_flag_ff <= 1'b0;
         rx_pin_short_flag_ff <= 1'b0;
         tx_stuck_dominant_flag_ff <= 1'b0;
         hs_off_ff <= 1'b0;
         hs_thermal_ff <= 1'b0;
         lin_ot_block_ff <= 1'b0;
         rx_short_block_ff <= 1'b0;
         tx_stuck_dominant_flag_block_ff <= 1'b0;
         tx_stuck_dominant_flag_cnt_ff <= 32'h0;
         wake_cnt_ff <= 32'h0;
         wake_armed_ff <= 1'b0;
      end else begin
         if (frame_ok) begin
            case (f_addr)
               `ADDR_MODE_CTRL: mode_ctrl_ff <= f_data;
               `ADDR_LIN_CTRL: lin_ctrl_ff <= f_data;
               `ADDR_HS_CTRL: hs_ctrl_ff <= f_data;
               `ADDR_IRQ_MASK: irq_mask_ff <= f_data;
               default: ;
            endcase
         end
         if (acc_volt) begin
            power_on_flag_ff <= 1'b0;
         end
         // high-side shutdown, re-enabled by control write when clear
         if (wr_hs && !hs_ot_s && !hv_shut) begin
            hs_off_ff <= 1'b0;
            hs_thermal_ff <= 1'b0;
         end
         if (hv_shut) begin
            hs_off_ff <= 1'b1;
         end
         if (hs_ot_s) begin
            hs_off_ff <= 1'b1;
            hs_thermal_ff <= 1'b1;
         end
         // lin overcurrent leaves tx alone
         if (loc_s) begin
            lin_overcurrent_flag_ff <= 1'b1;
         end else if (rd_lin) begin
            lin_overcurrent_flag_ff <= 1'b0;
         end
         if (lot_s) begin
            lin_overtemp_flag_ff <= 1'b1;
            lin_ot_block_ff <= 1'b1;
         end else if (txd_s && (lin_ot_block_ff || rd_lin)) begin
            lin_ot_block_ff <= 1'b0;
            if (rd_lin) begin
               lin_overtemp_flag_ff <= 1'b0;
            end
         end
         // set beats clear: short present keeps the flag
         if (rxsh_s) begin
            rx_pin_short_flag_ff <= 1'b1;
            rx_short_block_ff <= 1'b1;
         end else begin
            if (rd_lin) begin
               rx_pin_short_flag_ff <= 1'b0;
            end
            if (rxd_edge && txd_s) begin
               rx_short_block_ff <= 1'b0;
            end
         end
         // stuck dominant timer
         if (txd_s) begin
            tx_stuck_dominant_flag_cnt_ff <= 32'h0;
            tx_stuck_dominant_flag_block_ff <= 1'b0;
            if (rd_lin) begin
               tx_stuck_dominant_flag_ff <= 1'b0;
            end
         end else if (tx_stuck_dominant_flag_cnt_ff < TX_STUCK_DOMINANT_FLAG_CYCLES) begin
            tx_stuck_dominant_flag_cnt_ff <= tx_stuck_dominant_flag_cnt_ff + 32'h1;
         end else begin
            tx_stuck_dominant_flag_ff <= 1'b1;
            tx_stuck_dominant_flag_block_ff <= 1'b1;
         end
         // receive only set on errors; overcurrent must leave tx running
         if (tx_lin_err && mode != `MODE_STOP && mode != `MODE_SLEEP) begin
            lin_ctrl_ff[2] <= 1'b1;
         end
         // interrupt sources, set wins over the read clear
         if (frame_ok && f_addr == `ADDR_IRQ_SRC) begin
            irq_src_ff <= 4'h0;
         end
         if (hs_ot_s) begin
            irq_src_ff[`ISR_HS_BIT] <= 1'b1;
         end
         if (any_lin_err) begin
            irq_src_ff[`ISR_LIN_BIT] <= 1'b1;
         end
         if (|vstat_s[3:1]) begin
            irq_src_ff[`ISR_VM_BIT] <= 1'b1;
         end
         // lin wake: long dominant then rising edge
         if (low_power && !lin_ctrl_ff[2]) begin
            if (!bus_s) begin
               if (wake_cnt_ff < WAKE_CYCLES) begin
                  wake_cnt_ff <= wake_cnt_ff + 32'h1;
               end else begin
                  wake_armed_ff <= 1'b1;
               end
            end else begin
               wake_cnt_ff <= 32'h0;
               if (bus_rise && wake_armed_ff) begin
                  wake_armed_ff <= 1'b0;
                  irq_src_ff[`ISR_WAKE_BIT] <= 1'b1;
                  mode_ctrl_ff[1:0] <= `MODE_NORMAL;
               end
            end
         end else begin
            wake_cnt_ff <= 32'h0;
            wake_armed_ff <= 1'b0;
         end
      end
   end

   // registered outputs
   wire tx_block = lin_ot_block_ff || rx_short_block_ff || tx_stuck_dominant_flag_block_ff;
   wire hs_pend = irq_src_ff[`ISR_HS_BIT] && irq_mask_ff[`IMR_HS_BIT];
   wire lin_pend = irq_src_ff[`ISR_LIN_BIT] && irq_mask_ff[`IMR_LIN_BIT];
   wire vm_pend = irq_src_ff[`ISR_VM_BIT] && irq_mask_ff[`IMR_VM_BIT];
   wire wake_pend = irq_src_ff[`ISR_WAKE_BIT] && mode != `MODE_SLEEP;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         hs_drive_out <= 2'h0;
         lin_tx_enable_out <= 1'b0;
         lin_pullup_on_out <= 1'b1;
         lin_wake_thresh_out <= 1'b1;
         lin_slew_select_out <= `SLEW_20K;
         op_mode_out <= `MODE_NORMAL;
         rx_follow_bus_out <= 1'b0;
         wake_reset_out <= 1'b0;
         irq_n_out <= 1'b1;
      end else begin
         hs_drive_out <= hs_off_ff ? 2'h0 : hs_ctrl_ff[1:0];
         lin_tx_enable_out <= !tx_block && !low_power &&
            !lin_ctrl_ff[2];
         lin_pullup_on_out <= !low_power || mode_ctrl_ff[2];
         lin_wake_thresh_out <= mode_ctrl_ff[2];
         lin_slew_select_out <= lin_ctrl_ff[1:0];
         op_mode_out <= mode;
         rx_follow_bus_out <= mode == `MODE_STOP && lin_ctrl_ff[2];
         wake_reset_out <= mode == `MODE_SLEEP && bus_rise &&
            wake_armed_ff && !lin_ctrl_ff[2];
         // level output, held while a masked source is pending
         irq_n_out <= !(hs_pend || lin_pend || vm_pend ||
            wake_pend);
      end
   end
endmodule

// ==== bench/lin_hs_fault_spi_chk.sv ====
// checker for the lin fault and spi block, bound to its top
module lin_hs_fault_spi_chk #(
   parameter TX_STUCK_DOMINANT_FLAG_CYCLES = 50
) (
   input logic clk_in,
   input logic nrst_in,
   input logic por_in,
   input logic reset_mode_in,
   input logic external_reset_pin_in,
   input logic spi_cs_n_in,
   input logic spi_miso_oe_n_out,
   input logic hs_overtemp_in,
   input logic tx_input_pin_in,
   input logic [1:0] hs_drive_out,
   input logic lin_tx_enable_out,
   input logic lin_pullup_on_out,
   input logic lin_wake_thresh_out,
   input logic [1:0] op_mode_out,
   input logic irq_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int lo_cnt_ff;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // saturating count, a long repetition would choke the tools
   always_ff @(posedge clk_in)
      if (!nrst_in || tx_input_pin_in) lo_cnt_ff <= 0;
      else if (lo_cnt_ff < TX_STUCK_DOMINANT_FLAG_CYCLES + 8) lo_cnt_ff <= lo_cnt_ff + 1;
   sequence cs_open;
      $fell(spi_cs_n_in) ##1 !spi_cs_n_in [*5];
   endsequence
   sequence cs_idle;
      spi_cs_n_in [*4];
   endsequence
   sequence quiet_run;
      (spi_cs_n_in && external_reset_pin_in && !por_in && !reset_mode_in)
         [*6];
   endsequence
   chk_hs_ot_off: assert property (hs_overtemp_in [*5] |->
      hs_drive_out == 2'h0) else $error("hs drivers on in overtemp");
   chk_frame_drive: assert property (cs_open |->
      !spi_miso_oe_n_out) else $error("miso not driven in frame");
   chk_miso_idle: assert property (cs_idle |->
      spi_miso_oe_n_out) else $error("miso driven while cs high");
   chk_stop_tx: assert property ((op_mode_out == 2'h1) [*2] |->
      !lin_tx_enable_out) else $error("tx on in stop mode");
   chk_sleep_tx: assert property ((op_mode_out == 2'h2) [*2] |->
      !lin_tx_enable_out) else $error("tx on in sleep mode");
   chk_tx_stuck: assert property (lo_cnt_ff == TX_STUCK_DOMINANT_FLAG_CYCLES + 8 |->
      !lin_tx_enable_out) else $error("tx on with txd stuck low");
   chk_pullup_thr: assert property (
      (op_mode_out == 2'h1 || op_mode_out == 2'h2) [*2] |->
      lin_pullup_on_out == lin_wake_thresh_out)
      else $error("pull-up and threshold disagree");
   chk_irq_hold: assert property (quiet_run ##0 !irq_n_out |=>
      !irq_n_out) else $error("irq dropped without access");
endmodule

bind lin_hs_fault_spi lin_hs_fault_spi_chk #(
   .TX_STUCK_DOMINANT_FLAG_CYCLES(TX_STUCK_DOMINANT_FLAG_CYCLES)
) u_chk (.clk_in, .nrst_in, .por_in, .reset_mode_in,
   .external_reset_pin_in, .spi_cs_n_in, .spi_miso_oe_n_out,
   .hs_overtemp_in, .tx_input_pin_in, .hs_drive_out, .lin_tx_enable_out,
   .lin_pullup_on_out, .lin_wake_thresh_out, .op_mode_out, .irq_n_out);

// ==== bench/spi_master_model.sv ====
// spi master model: launches on sclk rise, samples on sclk fall
module spi_master_model (
   input logic clk_in,
   input logic miso_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic mosi_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // n below 8 makes a short frame on purpose
   task automatic xfer(input logic [7:0] tx, input int n,
      output logic [7:0] rx);
      rx = 8'h00;
      cs_n_out = 1'b0;
      tick(8);
      for (int i = 7; i > 7 - n; i--) begin
         sclk_out = 1'b1;
         mosi_out = tx[i];
         tick(4);
         rx[i] = miso_in;
         sclk_out = 1'b0;
         tick(4);
      end
      cs_n_out = 1'b1;
      // inverted last bit, so no stale bit lingers
      mosi_out = ~mosi_out;
      tick(8);
   endtask
endmodule

// ==== bench/test_lin_hs_fault_spi.sv ====
// self-checking bench for the lin fault and spi block
module test_lin_hs_fault_spi;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic external_reset_pin_in = 1'b1;
   logic por_in = 1'b0;
   logic [3:0] voltage_status_in = 4'h0;
   logic hs_overtemp_in = 1'b0;
   logic high_voltage_in = 1'b0;
   logic lin_overcurrent_in = 1'b0;
   logic lin_overtemp_in = 1'b0;
   logic rx_short_in = 1'b0;
   logic tx_input_pin_in = 1'b1;
   logic lin_bus_in = 1'b1;
   logic spi_cs_n_in, spi_sclk_in, spi_mosi_in, spi_miso_out;
   logic spi_miso_oe_n_out, lin_tx_enable_out, lin_pullup_on_out;
   logic lin_wake_thresh_out, rx_follow_bus_out, wake_reset_out, irq_n_out;
   logic [1:0] hs_drive_out, lin_slew_select_out, op_mode_out;
   logic [7:0] rx;
   int n_fail = 0;
   int tests_run = 0;
   always #4 clk_in = ~clk_in;
   // rxd mirrors the bus, as the receiver would
   lin_hs_fault_spi #(.TX_STUCK_DOMINANT_FLAG_CYCLES(50), .WAKE_CYCLES(10)) DUT (
      .clk_in, .nrst_in, .por_in, .reset_mode_in(1'b0),
      .external_reset_pin_in, .spi_cs_n_in, .spi_sclk_in, .spi_mosi_in,
      .spi_miso_out, .spi_miso_oe_n_out, .hs_overtemp_in, .high_voltage_in,
      .voltage_status_in, .hs_open_load_in(2'h0),
      .hs_current_limit_in(2'h0), .lin_overcurrent_in, .lin_overtemp_in,
      .rx_short_in, .tx_input_pin_in, .rx_output_pin_in(lin_bus_in),
      .lin_bus_in, .hs_drive_out, .lin_tx_enable_out, .lin_pullup_on_out,
      .lin_wake_thresh_out, .lin_slew_select_out, .op_mode_out,
      .rx_follow_bus_out, .wake_reset_out, .irq_n_out);
   spi_master_model u_m (.clk_in, .miso_in(spi_miso_out),
      .cs_n_out(spi_cs_n_in), .sclk_out(spi_sclk_in),
      .mosi_out(spi_mosi_in));
   task wrap_up;
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [3:0] d);
      u_m.xfer({a, d}, 8, rx);
      tick(4);
   endtask
   // reply carries the previous frame's register, so send twice
   task rd(input logic [3:0] a);
      u_m.xfer({a, 4'h0}, 8, rx);
      u_m.xfer({a, 4'h0}, 8, rx);
   endtask
   task xrst;
      external_reset_pin_in = 1'b0;
      tick(6);
      external_reset_pin_in = 1'b1;
      tick(6);
   endtask
   initial begin
      #200000;
      n_fail++;
      wrap_up;
   end
   initial begin
      tick(4);
      nrst_in = 1'b1;
      tick(4);
      chk("slew", lin_slew_select_out, 8'h1);
      chk("miso_oe", spi_miso_oe_n_out, 8'h1);
      for (int s = 0; s < 4; s++) begin
         wr(4'h4, 4'(s));
         chk("slew", lin_slew_select_out, 8'(s));
      end
      wr(4'h4, 4'h5);
      chk("tx_en", lin_tx_enable_out, 8'h0);
      wr(4'h4, 4'h1);
      wr(4'he, 4'h8);
      wr(4'h6, 4'h3);
      hs_overtemp_in = 1'b1;
      tick(6);
      chk("hs_drv", hs_drive_out, 8'h0);
      chk("irq_n", irq_n_out, 8'h0);
      rd(4'h7);
      chk("hs_stat", rx[3:0], 8'hf);
      chk("hs_sum", rx[5], 8'h1);
      hs_overtemp_in = 1'b0;
      tick(6);
      chk("hs_drv", hs_drive_out, 8'h0);
      wr(4'h6, 4'h3);
      chk("hs_drv", hs_drive_out, 8'h3);
      chk("irq_n", irq_n_out, 8'h0);
      wr(4'h0, 4'h8);
      high_voltage_in = 1'b1;
      tick(6);
      chk("hs_drv", hs_drive_out, 8'h0);
      high_voltage_in = 1'b0;
      tick(4);
      wr(4'h6, 4'h3);
      chk("hs_drv", hs_drive_out, 8'h3);
      u_m.xfer(8'h60, 7, rx);
      chk("hs_drv", hs_drive_out, 8'h3);
      xrst;
      chk("slew", lin_slew_select_out, 8'h1);
      chk("irq_n", irq_n_out, 8'h1);
      lin_overcurrent_in = 1'b1;
      tick(6);
      chk("irq_n", irq_n_out, 8'h1);
      chk("tx_en", lin_tx_enable_out, 8'h1);
      wr(4'he, 4'h2);
      chk("irq_n", irq_n_out, 8'h0);
      rd(4'h5);
      chk("oc_flag", rx[0], 8'h1);
      chk("lin_sum", rx[6], 8'h1);
      lin_overcurrent_in = 1'b0;
      lin_overtemp_in = 1'b1;
      rx_short_in = 1'b1;
      tick(6);
      chk("tx_en", lin_tx_enable_out, 8'h0);
      rd(4'h5);
      chk("ot_flag", rx[1], 8'h1);
      chk("rx_short", rx[3], 8'h1);
      lin_overtemp_in = 1'b0;
      rx_short_in = 1'b0;
      tick(6);
      wr(4'h4, 4'h1);
      chk("tx_en", lin_tx_enable_out, 8'h0);
      lin_bus_in = 1'b0;
      tick(4);
      lin_bus_in = 1'b1;
      tick(6);
      chk("tx_en", lin_tx_enable_out, 8'h1);
      rd(4'h5);
      chk("ot_flag", rx[1], 8'h0);
      chk("rx_short", rx[3], 8'h0);
      tx_input_pin_in = 1'b0;
      tick(70);
      chk("tx_en", lin_tx_enable_out, 8'h0);
      rd(4'h5);
      chk("tx_stuck_dominant_flag", rx[2], 8'h1);
      tx_input_pin_in = 1'b1;
      xrst;
      wr(4'h0, 4'h1);
      chk("pullup", lin_pullup_on_out, 8'h0);
      chk("thresh", lin_wake_thresh_out, 8'h0);
      wr(4'h4, 4'h5);
      chk("rx_follow", rx_follow_bus_out, 8'h1);
      xrst;
      wr(4'h0, 4'h5);
      chk("mode", op_mode_out, 8'h1);
      lin_bus_in = 1'b0;
      tick(20);
      lin_bus_in = 1'b1;
      for (int i = 0; i < 20 && irq_n_out !== 1'b0; i++) tick(1);
      chk("wake_irq", irq_n_out, 8'h0);
      xrst;
      wr(4'h0, 4'h6);
      lin_bus_in = 1'b0;
      tick(20);
      lin_bus_in = 1'b1;
      for (int i = 0; i < 20 && wake_reset_out !== 1'b1; i++) tick(1);
      chk("wake_rst", wake_reset_out, 8'h1);
      por_in = 1'b1;
      tick(2);
      por_in = 1'b0;
      tick(4);
      u_m.xfer(8'h10, 8, rx);
      chk("vms", rx[7], 8'h1);
      u_m.xfer(8'h10, 8, rx);
      chk("vms", rx[7], 8'h0);
      chk("vsr", rx[3:0], 8'h0);
      voltage_status_in = 4'h8;
      tick(4);
      u_m.xfer(8'h10, 8, rx);
      chk("vms", rx[7], 8'h1);
      chk("vsr", rx[3:0], 8'h8);
      wrap_up;
   end
endmodule
